// ---- spi_nand_pins.sv ----
// Purpose: pin-level serial interface of a serial flash device
// Assumes: serial clock far slower than CLK_SYS, sampled via synchroniser
// Notes: lanes two and three double as write protect and hold inputs
`timescale 1ns/1ps
`default_nettype none

module spi_nand_pins #(
    parameter int unsigned PROG_CYCLES = spi_nand_pkg::PROG_CYCLES
) (
    // clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        SYS_RST,
    // serial pins
    input  wire logic        CS_N,
    input  wire logic        SCK,
    input  wire logic [3:0]  LANE_IN,
    output var  logic [3:0]  LANE_OUT,
    output var  logic [3:0]  LANE_OE,
    output var  logic [3:0]  LANE_DIR,
    output var  logic        STANDBY,
    // register bus write
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output var  logic        S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output var  logic        S_AXI_WREADY,
    output var  logic [1:0]  S_AXI_BRESP,
    output var  logic        S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    // register bus read
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output var  logic        S_AXI_ARREADY,
    output var  logic [31:0] S_AXI_RDATA,
    output var  logic [1:0]  S_AXI_RRESP,
    output var  logic        S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY
);

    spi_nand_pkg::pins_s  s;
    spi_nand_pkg::pins_s  p;
    spi_nand_pkg::phase_e phase;
    spi_nand_pkg::prot_s  prot;
    spi_nand_pkg::prot_s  next_prot;
    spi_nand_pkg::stat_s  stat;
    logic        armed;
    logic        hold;
    logic        pend_in;
    logic        pend_out;
    logic        hold_en;
    logic        we;
    logic        busy;
    logic [15:0] busy_cnt;
    logic [5:0]  cnt;
    logic [31:0] in_sr;
    logic [31:0] out_sr;
    logic [7:0]  opcode;
    logic [31:0] rword;
    logic [31:0] feat_word;
    logic [7:0]  aw_addr;
    logic        aw_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        w_got;
    logic        do_wr;
    logic        sel;
    logic        cs_fall;
    logic        cs_rise;
    logic        sck_rise;
    logic        sck_fall;
    logic        hold_fall;
    logic        hold_rise;
    logic        rise_ok;
    logic        fall_ok;
    logic        hold_ctx;
    logic        commit;
    logic [7:0]  feat_addr;
    logic        live;

    // ----------------------------------------------------------------
    // pin sampling
    // ----------------------------------------------------------------
    lane_sync #(
        .W       (6),
        .RST_VAL (spi_nand_pkg::SYNC_RST)
    ) u_sync (
        .clk  (CLK_SYS),
        .rst  (SYS_RST),
        .din  ({CS_N, SCK, LANE_IN}),
        .dout (s)
    );

    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
            p <= spi_nand_pkg::SYNC_RST;
        else
            p <= s;
    end

    assign sel       = !s.cs_n;
    assign cs_fall   = p.cs_n && !s.cs_n;
    assign cs_rise   = !p.cs_n && s.cs_n;
    assign sck_rise  = !p.sck && s.sck;
    assign sck_fall  = p.sck && !s.sck;
    assign hold_fall = p.lanes[3] && !s.lanes[3];
    assign hold_rise = !p.lanes[3] && s.lanes[3];
    assign rise_ok   = sck_rise && sel && armed && !hold;
    assign fall_ok   = sck_fall && sel && armed && !hold;
    assign hold_ctx  = hold_en && sel && (phase != spi_nand_pkg::PH_OUT4);
    assign commit    = cs_rise && armed && (phase == spi_nand_pkg::PH_IN) && !busy;
    assign feat_addr = {in_sr[6:0], s.lanes[0]};

    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
            armed <= 1'b0;
        else if (cs_fall)
            armed <= 1'b1;
    end

    // ----------------------------------------------------------------
    // hold state
    // ----------------------------------------------------------------
    // hold timing
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST || !hold_ctx)
        begin
            hold     <= 1'b0;
            pend_in  <= 1'b0;
            pend_out <= 1'b0;
        end
        else if (!hold)
        begin
            pend_out <= 1'b0;
            if (hold_fall && !s.sck)
                hold <= 1'b1;
            else if (hold_fall)
                pend_in <= 1'b1;
            else if (hold_rise)
                pend_in <= 1'b0;
            else if (pend_in && sck_fall)
            begin
                hold    <= 1'b1;
                pend_in <= 1'b0;
            end
        end
        else
        begin
            pend_in <= 1'b0;
            if (hold_rise && !s.sck)
                hold <= 1'b0;
            else if (hold_rise)
                pend_out <= 1'b1;
            else if (hold_fall)
                pend_out <= 1'b0;
            else if (pend_out && sck_fall)
            begin
                hold     <= 1'b0;
                pend_out <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // serial sequencing
    // ----------------------------------------------------------------
    always_comb
    begin
        feat_word = 32'h0;
        if (feat_addr == spi_nand_pkg::FA_PROT)
            feat_word = {prot, 24'h0};
        else if (feat_addr == spi_nand_pkg::FA_STATUS)
            feat_word = {6'h0, we, busy, 24'h0};
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            phase  <= spi_nand_pkg::PH_OFF;
            cnt    <= 6'h0;
            in_sr  <= 32'h0;
            out_sr <= 32'h0;
            opcode <= 8'h0;
        end
        else if (cs_fall)
        begin
            phase <= spi_nand_pkg::PH_IN;
            cnt   <= 6'h0;
        end
        else if (!sel)
            phase <= spi_nand_pkg::PH_OFF;
        else if (rise_ok && phase != spi_nand_pkg::PH_OFF)
        begin
            in_sr <= {in_sr[30:0], s.lanes[0]};
            if (cnt != 6'h3f)
                cnt <= cnt + 6'h1;
            if (cnt == 6'h7)
                opcode <= feat_addr;
            if (phase == spi_nand_pkg::PH_IN && cnt == 6'hf && opcode == spi_nand_pkg::OP_GETF)
            begin
                out_sr <= feat_word;
                phase  <= spi_nand_pkg::PH_OUT1;
            end
            if (phase == spi_nand_pkg::PH_IN && cnt == 6'h1f)
            begin
                out_sr <= rword;
                if (opcode == spi_nand_pkg::OP_READ1)
                    phase <= spi_nand_pkg::PH_OUT1;
                if (opcode == spi_nand_pkg::OP_READ4)
                    phase <= spi_nand_pkg::PH_OUT4;
            end
        end
        else if (fall_ok && phase == spi_nand_pkg::PH_OUT1)
            out_sr <= {out_sr[30:0], out_sr[31]};
        else if (fall_ok && phase == spi_nand_pkg::PH_OUT4)
            out_sr <= {out_sr[27:0], out_sr[31:28]};
    end

    // ----------------------------------------------------------------
    // commands taking effect at deselect
    // ----------------------------------------------------------------
    always_comb
    begin
        next_prot = spi_nand_pkg::prot_s'(in_sr[7:0]);
        if (!s.lanes[2] && prot.lock_bits_write_disable)
        begin
            next_prot.block_protect_field = prot.block_protect_field;
            next_prot.protect_top_bottom  = prot.protect_top_bottom;
        end
        next_prot.spare = 2'h0;
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            prot <= '0;
            we   <= 1'b0;
        end
        else if (commit)
        begin
            if (cnt == spi_nand_pkg::N_CMD && opcode == spi_nand_pkg::OP_WREN)
                we <= 1'b1;
            if (cnt == spi_nand_pkg::N_CMD && opcode == spi_nand_pkg::OP_WRDI)
                we <= 1'b0;
            if (cnt == spi_nand_pkg::N_ADDR && opcode == spi_nand_pkg::OP_PEXEC)
                we <= 1'b0;
            if (cnt == spi_nand_pkg::N_SETF && opcode == spi_nand_pkg::OP_SETF
                && in_sr[15:8] == spi_nand_pkg::FA_PROT)
                prot <= next_prot;
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            busy     <= 1'b0;
            busy_cnt <= 16'h0;
        end
        else if (commit && we && cnt == spi_nand_pkg::N_ADDR
                 && opcode == spi_nand_pkg::OP_PEXEC)
        begin
            busy     <= 1'b1;
            busy_cnt <= 16'(PROG_CYCLES - 1);
        end
        else if (busy_cnt != 16'h0)
            busy_cnt <= busy_cnt - 16'h1;
        else
            busy <= 1'b0;
    end

    // ----------------------------------------------------------------
    // pin drive
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            LANE_OUT <= 4'h0;
            LANE_OE  <= 4'h0;
            LANE_DIR <= spi_nand_pkg::DIR_DESEL;
            STANDBY  <= 1'b0;
            live     <= 1'b0;
        end
        else
        begin
            STANDBY <= !sel && !busy;
            if (!sel)
            begin
                LANE_OE  <= 4'h0;
                LANE_DIR <= spi_nand_pkg::DIR_DESEL;
                live     <= 1'b0;
            end
            else
            begin
                LANE_DIR <= (phase == spi_nand_pkg::PH_OUT4) ? 4'hf : 4'h2;
                if (fall_ok && phase == spi_nand_pkg::PH_OUT1)
                begin
                    LANE_OUT <= {2'h0, out_sr[31], 1'b0};
                    LANE_OE  <= 4'h2;
                    live     <= 1'b1;
                end
                else if (fall_ok && phase == spi_nand_pkg::PH_OUT4)
                begin
                    LANE_OUT <= out_sr[31:28];
                    LANE_OE  <= 4'hf;
                    live     <= 1'b1;
                end
                // held bit is driven again once hold ends
                else if (live && phase == spi_nand_pkg::PH_OUT1)
                    LANE_OE <= 4'h2;
                if (hold || phase == spi_nand_pkg::PH_IN)
                    LANE_OE <= 4'h0;
            end
        end
    end

    // ----------------------------------------------------------------
    // register bus slave
    // ----------------------------------------------------------------
    assign do_wr = aw_got && w_got && !S_AXI_BVALID;
    assign stat  = '{armed, hold, STANDBY, sel, we, busy};

    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            aw_got        <= 1'b0;
            aw_addr       <= 8'h0;
            S_AXI_AWREADY <= 1'b0;
        end
        else if (S_AXI_AWVALID && S_AXI_AWREADY)
        begin
            aw_got        <= 1'b1;
            aw_addr       <= S_AXI_AWADDR;
            S_AXI_AWREADY <= 1'b0;
        end
        else if (do_wr)
            aw_got <= 1'b0;
        else if (!aw_got && !S_AXI_BVALID)
            S_AXI_AWREADY <= 1'b1;
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            w_got        <= 1'b0;
            w_data       <= 32'h0;
            w_strb       <= 4'h0;
            S_AXI_WREADY <= 1'b0;
        end
        else if (S_AXI_WVALID && S_AXI_WREADY)
        begin
            w_got        <= 1'b1;
            w_data       <= S_AXI_WDATA;
            w_strb       <= S_AXI_WSTRB;
            S_AXI_WREADY <= 1'b0;
        end
        else if (do_wr)
            w_got <= 1'b0;
        else if (!w_got && !S_AXI_BVALID)
            S_AXI_WREADY <= 1'b1;
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            hold_en      <= spi_nand_pkg::HOLD_EN_RST;
            rword        <= spi_nand_pkg::RWORD_RST;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= 2'h0;
        end
        else if (do_wr)
        begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= 2'h0;
            if (aw_addr == spi_nand_pkg::OFF_CTRL && w_strb[0])
                hold_en <= w_data[0];
            else if (aw_addr == spi_nand_pkg::OFF_RWORD)
            begin
                for (int i = 0; i < 4; i++)
                begin
                    if (w_strb[i])
                        rword[i*8 +: 8] <= w_data[i*8 +: 8];
                end
            end
            else if (aw_addr != spi_nand_pkg::OFF_STATUS && aw_addr != spi_nand_pkg::OFF_PROT)
                S_AXI_BRESP <= 2'h2;
        end
        else if (S_AXI_BREADY)
            S_AXI_BVALID <= 1'b0;
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0;
            S_AXI_RRESP   <= 2'h0;
        end
        else if (S_AXI_ARVALID && S_AXI_ARREADY)
        begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b1;
            S_AXI_RRESP   <= 2'h0;
            case (S_AXI_ARADDR)
                spi_nand_pkg::OFF_CTRL:   S_AXI_RDATA <= {31'h0, hold_en};
                spi_nand_pkg::OFF_STATUS: S_AXI_RDATA <= {26'h0, stat};
                spi_nand_pkg::OFF_PROT:   S_AXI_RDATA <= {24'h0, prot};
                spi_nand_pkg::OFF_RWORD:  S_AXI_RDATA <= rword;
                default:
                begin
                    S_AXI_RDATA <= 32'h0;
                    S_AXI_RRESP <= 2'h2;
                end
            endcase
        end
        else if (S_AXI_RVALID && S_AXI_RREADY)
            S_AXI_RVALID <= 1'b0;
        else if (!S_AXI_RVALID)
            S_AXI_ARREADY <= 1'b1;
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);

    desel_float_a: assert property (!sel |=> LANE_OE == 4'h0)
        else $error("lanes driven while deselected");
    unarmed_quiet_a: assert property (!armed |=> $stable(prot) && !we)
        else $error("command accepted before first select edge");
    standby_busy_a: assert property ($rose(busy) |=> !STANDBY [*2])
        else $error("standby during program");
    commit_edge_a: assert property (!$stable(prot) |-> $past(cs_rise))
        else $error("protection changed away from deselect");
    capture_rise_a: assert property (cnt > $past(cnt) |-> $past(sck_rise))
        else $error("bit counted without clock rise");
    out_fall_a: assert property (!$stable(LANE_OUT) |-> $past(sck_fall))
        else $error("output changed without clock fall");
    lock_keep_a: assert property (commit && !s.lanes[2] && prot.lock_bits_write_disable
        |=> $stable(prot.block_protect_field) && $stable(prot.protect_top_bottom))
        else $error("locked protect bits changed");
    desel_dir_a: assert property (cs_rise |=> LANE_DIR == spi_nand_pkg::DIR_DESEL)
        else $error("wrong default lane direction");
    hold_off_a: assert property (!hold_en |=> !hold)
        else $error("hold entered while disabled");
    hold_float_a: assert property (hold |=> LANE_OE == 4'h0)
        else $error("output driven in hold");
    hold_enter_a: assert property (hold_ctx && !hold && hold_fall && !s.sck |=> hold)
        else $error("hold not entered at hold edge");
    quad_nohold_a: assert property (phase == spi_nand_pkg::PH_OUT4 |=> !hold)
        else $error("hold active in quad phase");

endmodule

`default_nettype wire

// ---- spi_nand_pkg.sv ----
// Purpose: shared constants and types of the serial flash pin interface
// Assumes: 25 MHz system clock, register bus with 8-bit byte addresses
// Notes:
package spi_nand_pkg;

    // register offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_PROT   = 8'h08;
    localparam logic [7:0] OFF_RWORD  = 8'h0c;

    // reset values
    localparam logic        HOLD_EN_RST = 1'b0;
    localparam logic [31:0] RWORD_RST   = 32'h0000_0000;
    localparam logic [3:0]  DIR_DESEL   = 4'ha;
    localparam logic [5:0]  SYNC_RST    = 6'h3f;

    // serial opcodes and feature addresses
    localparam logic [7:0] OP_WREN   = 8'h06;
    localparam logic [7:0] OP_WRDI   = 8'h04;
    localparam logic [7:0] OP_GETF   = 8'h0f;
    localparam logic [7:0] OP_SETF   = 8'h1f;
    localparam logic [7:0] OP_PEXEC  = 8'h10;
    localparam logic [7:0] OP_READ1  = 8'h03;
    localparam logic [7:0] OP_READ4  = 8'h6b;
    localparam logic [7:0] FA_PROT   = 8'ha0;
    localparam logic [7:0] FA_STATUS = 8'hc0;

    // bit counts at which sequences are complete
    localparam logic [5:0] N_CMD  = 6'd8;
    localparam logic [5:0] N_SETF = 6'd24;
    localparam logic [5:0] N_ADDR = 6'd32;

    // program busy time
    localparam int unsigned PROG_TIME_US = 200;
    localparam int unsigned CLK_MHZ      = 25;
    localparam int unsigned PROG_CYCLES  = PROG_TIME_US * CLK_MHZ;

    typedef enum logic [1:0] {PH_OFF, PH_IN, PH_OUT1, PH_OUT4} phase_e;

    typedef struct packed {
        logic       cs_n;
        logic       sck;
        logic [3:0] lanes;
    } pins_s;

    typedef struct packed {
        logic       lock_bits_write_disable;
        logic [3:0] block_protect_field;
        logic       protect_top_bottom;
        logic [1:0] spare;
    } prot_s;

    typedef struct packed {
        logic armed;
        logic hold;
        logic standby;
        logic selected;
        logic write_enable;
        logic busy;
    } stat_s;

endpackage

// ---- lane_sync.sv ----
// Purpose: two-stage synchroniser for pin inputs
// Assumes: synchronous active-high reset
// Notes: only the second stage leaves this module
`timescale 1ns/1ps
`default_nettype none

module lane_sync #(
    parameter int          W       = 6,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // data
    input  wire logic [W-1:0] din,
    output var  logic [W-1:0] dout
);

    logic [W-1:0] meta;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta <= RST_VAL;
            dout <= RST_VAL;
        end
        else
        begin
            meta <= din;
            dout <= meta;
        end
    end

endmodule

`default_nettype wire

// ---- spi_host_model.sv ----
// Purpose: host serial controller model facing the pin block
// Assumes: mode 0, sck half period of four system clocks
// Notes: released lanes read high, lane zero inverts instead
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    // clock
    input  wire logic       CLK_SYS,
    // device pins
    output var  logic       CS_N,
    output var  logic       SCK,
    output var  logic [3:0] LANE_IN,
    input  wire logic [3:0] LANE_OUT,
    input  wire logic [3:0] LANE_OE
);
    logic [3:0]  hv = 4'hd;
    logic [3:0]  hen = 4'hd;
    logic [31:0] t;
    initial CS_N = 1'b1;
    initial SCK = 1'b0;
    always_comb
        for (int i = 0; i < 4; i++)
            LANE_IN[i] = LANE_OE[i] ? LANE_OUT[i] : hen[i] ? hv[i] : (i != 0) | ~hv[0];
    task automatic tick(input int n);
        repeat (n) @(posedge CLK_SYS);
    endtask
    task automatic sel(input logic v);
        tick(4);
        CS_N <= v;
        tick(4);
    endtask
    // msb first, sampled at the rise
    task automatic shift(input logic [31:0] tx, input int n, input int m,
                         output logic [31:0] rx);
        rx = '0;
        hen <= (m == 2) ? 4'h0 : (m == 1) ? 4'hc : 4'hd;
        for (int i = n - 1; i >= 0; i--)
        begin
            hv[0] <= (m == 0) ? tx[i] : ~hv[0];
            tick(4);
            SCK <= 1'b1;
            rx = (m == 2) ? {rx[27:0], LANE_IN} : {rx[30:0], LANE_IN[1]};
            tick(4);
            SCK <= 1'b0;
        end
    endtask
    task automatic cmd(input logic [31:0] tx, input int n);
        sel(1'b0);
        shift(tx, n, 0, t);
        sel(1'b1);
    endtask
    // pause mid read, two clocks meanwhile
    task automatic hread(output logic [31:0] v, output logic oe);
        sel(1'b0);
        shift(32'h03000000, 32, 0, v);
        shift(0, 8, 1, v);
        hv[3] <= 1'b0;
        tick(8);
        oe = LANE_OE[1];
        shift(0, 2, 0, t);
        hv[3] <= 1'b1;
        tick(8);
        shift(0, 8, 1, v);
        sel(1'b1);
    endtask
endmodule
`default_nettype wire

// ---- spi_nand_pins_tb_top.sv ----
// Purpose: self-checking bench of the serial flash pin block
// Assumes: host model in mode 0, sck period 320 ns
// Notes: short program time keeps the run brief
`timescale 1ns/1ps
`default_nettype none
module spi_nand_pins_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  awaddr, araddr;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic [31:0] wdata, rdata, r;
    logic [3:0]  wstrb;
    logic        awready, wready, bvalid, arready, rvalid, cs_n, sck, standby, oe;
    logic [1:0]  bresp, rresp, resp;
    logic [3:0]  lane_in, lane_out, lane_oe, lane_dir;
    int          error_cnt = 0, checked = 0, cyc = 0;
    always #20 clk = ~clk;
    spi_nand_pins #(.PROG_CYCLES(20)) spi_nand_pins_i (
        .CLK_SYS(clk), .SYS_RST(rst), .CS_N(cs_n), .SCK(sck), .LANE_IN(lane_in),
        .LANE_OUT(lane_out), .LANE_OE(lane_oe), .LANE_DIR(lane_dir), .STANDBY(standby),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    spi_host_model spi_host_model_i (.CLK_SYS(clk), .CS_N(cs_n), .SCK(sck),
        .LANE_IN(lane_in), .LANE_OUT(lane_out), .LANE_OE(lane_oe));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize;
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // a hang counts as a mismatch
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            error_cnt++;
            summarize();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        resp = bresp;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        r = rdata;
        resp = rresp;
        @(posedge clk);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        awaddr <= 8'h00;
        araddr <= 8'h00;
        wdata <= 32'h0;
        wstrb <= 4'hf;
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        bready <= 1'b0;
        arvalid <= 1'b0;
        rready <= 1'b0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        chk("standby", standby, 1);
        chk("dir", lane_dir, 4'ha);
        chk("oe", lane_oe, 4'h0);
        wr(8'h0c, 32'h1234abcd);
        rd(8'h10);
        chk("unmapped", resp, 2'b10);
        wr(8'h04, 0);
        chk("ro write", resp, 2'b00);
        spi_host_model_i.cmd(32'h1fa05c, 24);
        rd(8'h08);
        chk("prot", r, 32'h5c);
        spi_host_model_i.cmd(32'h1fa00, 20);
        rd(8'h08);
        chk("short", r, 32'h5c);
        spi_host_model_i.cmd(32'h1fa0c4, 24);
        spi_host_model_i.hv[2] <= 1'b0;
        spi_host_model_i.cmd(32'h1fa080, 24);
        rd(8'h08);
        chk("locked", r, 32'hc4);
        spi_host_model_i.hv[2] <= 1'b1;
        spi_host_model_i.cmd(32'h06, 8);
        spi_host_model_i.sel(1'b0);
        spi_host_model_i.shift(32'h0fc0, 16, 0, r);
        spi_host_model_i.shift(0, 8, 1, r);
        spi_host_model_i.sel(1'b1);
        chk("status", r, 32'h02);
        spi_host_model_i.cmd(32'h10000000, 32);
        spi_host_model_i.tick(2);
        chk("busy", standby, 0);
        spi_host_model_i.tick(40);
        chk("idle", standby, 1);
        spi_host_model_i.cmd(32'h06, 8);
        spi_host_model_i.cmd(32'h04, 8);
        rd(8'h04);
        chk("disabled", r, 32'h28);
        spi_host_model_i.sel(1'b0);
        spi_host_model_i.shift(32'h6b000000, 32, 0, r);
        spi_host_model_i.shift(0, 8, 2, r);
        chk("quad oe", lane_oe, 4'hf);
        chk("quad dir", lane_dir, 4'hf);
        spi_host_model_i.sel(1'b1);
        chk("quad", r, 32'h1234abcd);
        spi_host_model_i.hread(r, oe);
        chk("no hold", {oe, r[7:0]}, 9'h1d2);
        wr(8'h00, 1);
        spi_host_model_i.hread(r, oe);
        chk("hold", {oe, r[7:0]}, 9'h034);
        wstrb <= 4'h6;
        wr(8'h0c, 32'hffffffff);
        rd(8'h0c);
        chk("strobe", r, 32'h12ffffcd);
        wstrb <= 4'he;
        wr(8'h00, 0);
        chk("ctrl strobe", resp, 2'b10);
        rd(8'h00);
        chk("ctrl kept", r, 32'h1);
        summarize();
    end
endmodule
`default_nettype wire
